// File: ahcr_pkg.sv
// Package: adapter control register layout, reset values and structs
package ahcr_pkg;
    // ==================================================
    // Field positions
    localparam int BIT_STRAP0 = 0;
    localparam int BIT_STRAP2 = 2;
    localparam int BIT_HOLD_ACK = 4;
    localparam int BIT_DIR = 5;
    localparam int BIT_BUS_REQ = 6;
    localparam int BIT_PDMA_EN = 7;
    localparam int BIT_ADAPTER_RESET_BIT = 8;
    localparam int BIT_HALT = 9;
    localparam int BIT_BOOT = 10;
    localparam int BIT_LBP = 11;
    localparam int BIT_IRQ_EN = 12;
    localparam int BIT_PEN = 13;
    localparam int BIT_NSEL0 = 14;
    localparam int BIT_NSEL1 = 15;
    // ==================================================
    // Reset values
    localparam logic RST_ADAPTER_RESET_BIT = 1'h0;
    localparam logic RST_HALT_NOBOOT = 1'h1;
    localparam logic RST_LBP = 1'h0;
    localparam logic RST_IRQ_EN = 1'h1;
    localparam logic RST_NSEL0 = 1'h0;
    localparam logic RST_NSEL1 = 1'h1;
    localparam logic [1:0] NSEL_16M = 2'h2; // {sel1,sel0}
    localparam logic [1:0] NSEL_4M = 2'h3;
    // ==================================================
    // Host write access
    typedef struct packed {
        logic we;
        logic [1:0] be;   // [1]=msb byte, [0]=lsb byte
        logic [15:0] data;
    } ahcr_wr_s;
    // Clock monitor flags
    typedef struct packed {
        logic osc_bad;
        logic phy_xtal_bad;
        logic rclk_bad;
        logic system_bus_clock_bad;
    } ahcr_clkmon_s;
endpackage

// File: ahcr_field.sv
// One writable control bit with protect and set-only options
`timescale 1ns/10ps
module ahcr_field #(
    parameter logic RST_VAL = 1'h0,
    parameter bit PROTECTED = 1'b0,
    parameter bit SET_ONLY = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_rst_val_sel,   // Use i_rst_val instead of RST_VAL
    input wire logic i_rst_val,
    input wire logic i_wr,
    input wire logic i_wdata,
    input wire logic i_adapter_reset_bit,        // Adapter reset bit currently set
    input wire logic i_force_clr,     // Hardware clear, wins over write
    output logic o_q
);
    logic q_q;
    logic q_d;
    logic wr_ok;
    // Protected fields only take writes during adapter reset
    assign wr_ok = i_wr && (!PROTECTED || i_adapter_reset_bit);
    // Set-only fields may go high but never be written low
    assign q_d = i_force_clr ? 1'b0 :
                 !wr_ok ? q_q :
                 SET_ONLY ? (q_q | i_wdata) : i_wdata;
    // ==================================================
    // Storage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q_q <= i_rst_val_sel ? i_rst_val : RST_VAL;
        end else begin
            q_q <= q_d;
        end
    end
    assign o_q = q_q;
endmodule

// File: ahcr_top.sv
// Adapter host control register: pseudo-DMA, reset, boot and net select
`timescale 1ns/10ps
module ahcr_top
    import ahcr_pkg::*;
(
    input wire logic i_clk,               // System bus clock
    input wire logic i_rst,               // External reset pin
    input wire ahcr_wr_s i_wr,            // Host direct-I/O write
    input wire logic i_rd,                // Host direct-I/O read
    input wire ahcr_clkmon_s i_clkmon,    // Clock monitor flags
    input wire logic i_intel_mode,        // Bus type strap, 1 = Intel
    input wire logic i_boot_strap,        // Boot memory strap
    input wire logic i_parity_strap,      // Parity enable strap
    input wire logic i_net_type_strap0,
    input wire logic i_net_type_strap2,
    input wire logic i_dma_direction_pin, // Current pseudo-DMA direction
    input wire logic i_bus_request_pin,   // Raw bus request pin level
    input wire logic i_hold_ack_pin,      // External hold-ack / grant
    input wire logic i_status_irq,        // Status register interrupt pending
    input wire logic i_parity_err_raw,    // Internal parity mismatch seen
    input wire logic i_boot_region,       // Access hits chapters 0 or 31
    input wire logic i_mem_strobe,        // Memory cycle strobe from core
    output logic [15:0] o_rdata,          // Register read data
    output logic o_core_reset,            // Reset to rest of device
    output logic o_cp_bus_grant,          // Processor allowed on buses
    output logic o_memory_column_strobe,
    output logic o_memory_rom_enable,
    output logic o_local_bus_priority,
    output logic o_master_dma_allowed,
    output logic o_pdma_active,
    output logic o_pdma_irq,
    output logic o_hold_ack,              // Acknowledge used by core DMA
    output logic o_system_irq_pin,
    output logic o_parity_error,
    output logic o_net_select_out0,
    output logic o_net_select_out1
);
    // ==================================================
    // Write strobes per byte
    logic wr_lo;
    logic wr_hi;
    logic clk_bad;
    logic adapter_reset_bit;
    logic hold_ack;
    logic dir_q;
    logic bus_req_q;
    logic pdma_en;
    logic halt;
    logic boot;
    logic local_bus_priority;
    logic irq_en;
    logic parity_check_enable;
    logic nsel0;
    logic nsel1;
    logic bus_req_now;
    logic irq_d;
    logic [15:0] rdata_d;
    logic [15:0] rdata_q;
    logic irq_q;
    logic cas_q;
    logic rom_q;
    logic perr_q;
    logic [15:0] wd;

    assign wd = i_wr.data;
    assign wr_lo = i_wr.we && i_wr.be[0];
    assign wr_hi = i_wr.we && i_wr.be[1];
    // Any bad monitored clock forces adapter reset
    assign clk_bad = |i_clkmon;

    // ==================================================
    // Control fields
    // Adapter reset: set-by-hardware wins over a host write of 0
    ahcr_field #(.RST_VAL(RST_ADAPTER_RESET_BIT)) u_adapter_reset_bit (
        .i_clk(i_clk), .i_rst(i_rst), .i_rst_val_sel(1'b0), .i_rst_val(1'b0),
        .i_wr(wr_hi || clk_bad), .i_wdata(wd[BIT_ADAPTER_RESET_BIT] | clk_bad),
        .i_adapter_reset_bit(1'b0), .i_force_clr(1'b0), .o_q(adapter_reset_bit)
    );
    // Hold-ack: protected, cleared whenever pseudo-DMA off
    ahcr_field #(.RST_VAL(1'h0), .PROTECTED(1'b1)) u_hlda (
        .i_clk(i_clk), .i_rst(i_rst), .i_rst_val_sel(1'b0), .i_rst_val(1'b0),
        .i_wr(wr_lo), .i_wdata(wd[BIT_HOLD_ACK]), .i_adapter_reset_bit(adapter_reset_bit),
        .i_force_clr(!pdma_en), .o_q(hold_ack)
    );
    // Pseudo-DMA enable is set-only
    ahcr_field #(.RST_VAL(1'h0), .SET_ONLY(1'b1)) u_pdma (
        .i_clk(i_clk), .i_rst(i_rst), .i_rst_val_sel(1'b0), .i_rst_val(1'b0),
        .i_wr(wr_lo), .i_wdata(wd[BIT_PDMA_EN]), .i_adapter_reset_bit(adapter_reset_bit),
        .i_force_clr(1'b0), .o_q(pdma_en)
    );
    ahcr_field #(.RST_VAL(RST_HALT_NOBOOT), .PROTECTED(1'b1)) u_halt (
        .i_clk(i_clk), .i_rst(i_rst), .i_rst_val_sel(1'b1), .i_rst_val(!i_boot_strap),
        .i_wr(wr_hi), .i_wdata(wd[BIT_HALT]), .i_adapter_reset_bit(adapter_reset_bit),
        .i_force_clr(1'b0), .o_q(halt)
    );
    ahcr_field #(.RST_VAL(1'h0), .PROTECTED(1'b1)) u_boot (
        .i_clk(i_clk), .i_rst(i_rst), .i_rst_val_sel(1'b1), .i_rst_val(i_boot_strap),
        .i_wr(wr_hi), .i_wdata(wd[BIT_BOOT]), .i_adapter_reset_bit(adapter_reset_bit),
        .i_force_clr(1'b0), .o_q(boot)
    );
    ahcr_field #(.RST_VAL(RST_LBP)) u_lbp (
        .i_clk(i_clk), .i_rst(i_rst), .i_rst_val_sel(1'b0), .i_rst_val(1'b0),
        .i_wr(wr_hi), .i_wdata(wd[BIT_LBP]), .i_adapter_reset_bit(adapter_reset_bit),
        .i_force_clr(1'b0), .o_q(local_bus_priority)
    );
    ahcr_field #(.RST_VAL(RST_IRQ_EN)) u_irqen (
        .i_clk(i_clk), .i_rst(i_rst), .i_rst_val_sel(1'b0), .i_rst_val(1'b0),
        .i_wr(wr_hi), .i_wdata(wd[BIT_IRQ_EN]), .i_adapter_reset_bit(adapter_reset_bit),
        .i_force_clr(1'b0), .o_q(irq_en)
    );
    ahcr_field #(.RST_VAL(1'h0), .PROTECTED(1'b1)) u_pen (
        .i_clk(i_clk), .i_rst(i_rst), .i_rst_val_sel(1'b1), .i_rst_val(i_parity_strap),
        .i_wr(wr_hi), .i_wdata(wd[BIT_PEN]), .i_adapter_reset_bit(adapter_reset_bit),
        .i_force_clr(1'b0), .o_q(parity_check_enable)
    );
    // Net select: protected, power-up to 16 Mbit/s
    ahcr_field #(.RST_VAL(RST_NSEL0), .PROTECTED(1'b1)) u_nsel0 (
        .i_clk(i_clk), .i_rst(i_rst), .i_rst_val_sel(1'b0), .i_rst_val(1'b0),
        .i_wr(wr_hi), .i_wdata(wd[BIT_NSEL0]), .i_adapter_reset_bit(adapter_reset_bit),
        .i_force_clr(1'b0), .o_q(nsel0)
    );
    ahcr_field #(.RST_VAL(RST_NSEL1), .PROTECTED(1'b1)) u_nsel1 (
        .i_clk(i_clk), .i_rst(i_rst), .i_rst_val_sel(1'b0), .i_rst_val(1'b0),
        .i_wr(wr_hi), .i_wdata(wd[BIT_NSEL1]), .i_adapter_reset_bit(adapter_reset_bit),
        .i_force_clr(1'b0), .o_q(nsel1)
    );

    // ==================================================
    // Pseudo-DMA decode
    // Bus request polarity fixed so 1 always means requested
    assign bus_req_now = i_intel_mode ? i_bus_request_pin : !i_bus_request_pin;
    // Pin acknowledge ignored once pseudo-DMA selected
    assign o_hold_ack = pdma_en ? hold_ack : i_hold_ack_pin;
    assign o_pdma_active = pdma_en && bus_req_now && hold_ack;
    assign o_pdma_irq = pdma_en && bus_req_now && !hold_ack;
    assign o_master_dma_allowed = !pdma_en;
    assign irq_d = o_pdma_irq || (irq_en && i_status_irq);
    assign o_core_reset = i_rst || adapter_reset_bit;
    assign o_cp_bus_grant = !halt && !o_core_reset;
    assign o_local_bus_priority = local_bus_priority;

    // Read image; bit 3 reserved reads zero, bit 1 unconnected reads zero
    assign rdata_d = {nsel1, nsel0, parity_check_enable, irq_en, local_bus_priority, boot, halt, adapter_reset_bit,
                      pdma_en, bus_req_q, dir_q, hold_ack, 1'b0,
                      i_net_type_strap2, 1'b0, i_net_type_strap0};

    // ==================================================
    // Status sampling, outputs from flip-flops
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dir_q <= 1'b0;
            bus_req_q <= 1'b0;
            irq_q <= 1'b0;
            rdata_q <= 16'h0000;
            cas_q <= 1'b0;
            rom_q <= 1'b0;
            perr_q <= 1'b0;
        end else begin
            dir_q <= i_dma_direction_pin;
            bus_req_q <= bus_req_now;
            irq_q <= irq_d;
            // Read data latched only on a read so it stays put for host
            if (i_rd) begin
                rdata_q <= rdata_d;
            end
            // RAM uses column strobe, ROM uses rom enable in boot chapters
            cas_q <= i_mem_strobe && (boot || !i_boot_region);
            rom_q <= i_mem_strobe && !boot && i_boot_region;
            perr_q <= parity_check_enable && i_parity_err_raw;
        end
    end

    assign o_rdata = rdata_q;
    assign o_system_irq_pin = irq_q;
    assign o_memory_column_strobe = cas_q;
    assign o_memory_rom_enable = rom_q;
    assign o_parity_error = perr_q;
    assign o_net_select_out0 = nsel0;
    assign o_net_select_out1 = nsel1;

    // ==================================================
    // Assertions
    a_hlda_needs_pdma: assert property (@(posedge i_clk) disable iff (i_rst)
        !pdma_en |-> !hold_ack) else $error("hold ack set without pseudo-DMA");
    a_clkfail_adapter_reset_bit: assert property (@(posedge i_clk) disable iff (i_rst)
        clk_bad |=> adapter_reset_bit) else $error("clock fail did not set adapter reset");
    a_nsel_protect: assert property (@(posedge i_clk) disable iff (i_rst)
        !adapter_reset_bit |=> $stable({nsel1, nsel0})) else $error("net select changed");
    a_pen_protect: assert property (@(posedge i_clk) disable iff (i_rst)
        !adapter_reset_bit |=> $stable({parity_check_enable, boot, halt})) else $error("protected changed");
    a_irq_pin: assert property (@(posedge i_clk) disable iff (i_rst)
        irq_d |=> o_system_irq_pin) else $error("irq pin missed");
    a_ack_source: assert property (@(posedge i_clk) disable iff (i_rst)
        pdma_en |-> o_hold_ack == hold_ack) else $error("pin ack used");
    a_core_reset: assert property (@(posedge i_clk)
        adapter_reset_bit |-> o_core_reset && !o_cp_bus_grant) else $error("reset not held");
    a_rom_boot: assert property (@(posedge i_clk) disable iff (i_rst)
        boot |=> !o_memory_rom_enable) else $error("rom enable in ram boot");
    a_nsel_reset: assert property (@(posedge i_clk)
        $past(i_rst) |-> {nsel1, nsel0} == NSEL_16M) else $error("bad nsel reset");
    c_pdma_irq: cover property (@(posedge i_clk) o_pdma_irq);
    c_pdma_active: cover property (@(posedge i_clk) o_pdma_active);
    c_nsel_4m: cover property (@(posedge i_clk) {nsel1, nsel0} == NSEL_4M);
endmodule

// File: ahcr_host.sv
// Host processor model driving the adapter control register port
`timescale 1ns/10ps
module ahcr_host
    import ahcr_pkg::*;
(
    input wire logic i_clk,
    input wire logic [15:0] i_rdata,
    output ahcr_wr_s o_wr,
    output logic o_rd
);
    // ==================================================
    // Bus idle at time zero
    initial begin
        o_wr = '0;
        o_rd = 1'b0;
    end
    // One write strobe; data lines show the inverse once released
    task automatic wr(input logic [1:0] be, input logic [15:0] d);
        @(negedge i_clk);
        o_wr <= '{we: 1'b1, be: be, data: d};
        @(negedge i_clk);
        o_wr <= '{we: 1'b0, be: 2'h0, data: ~d};
    endtask
    // Read strobe; data is settled one edge after it
    task automatic rd(output logic [15:0] d);
        @(negedge i_clk);
        o_rd <= 1'b1;
        @(negedge i_clk);
        o_rd <= 1'b0;
        d = i_rdata;
    endtask
endmodule

// File: adapter_host_control_register_tb.sv
// Self-checking bench for the adapter control register
`timescale 1ns/10ps
module adapter_host_control_register_tb;
    import ahcr_pkg::*;
    // ==================================================
    // Stimulus, outputs and bookkeeping
    logic i_clk = 1'b0, i_rst = 1'b1, rd;
    ahcr_wr_s wr;
    ahcr_clkmon_s clkmon = '0;
    logic intel = 1, boot_s = 0, par_s = 0, st0 = 0, st2 = 0, dir = 0, breq = 0;
    logic hpin = 0, sirq = 0, perr = 0, breg = 1, mstb = 1;
    logic [15:0] rdata, m; // m mirrors the writable bits
    logic core, grant, memory_column_strobe, mrom, local_bus_priority, mdma, pact, pirq, hack, irq, pe_o, ns0, ns1;
    int err_count = 0, checked = 0, cyc = 0, seed = 26781;
    ahcr_host host (.i_clk(i_clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd));
    ahcr_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_wr(wr), .i_rd(rd), .i_clkmon(clkmon),
        .i_intel_mode(intel), .i_boot_strap(boot_s), .i_parity_strap(par_s),
        .i_net_type_strap0(st0), .i_net_type_strap2(st2), .i_dma_direction_pin(dir),
        .i_bus_request_pin(breq), .i_hold_ack_pin(hpin), .i_status_irq(sirq),
        .i_parity_err_raw(perr), .i_boot_region(breg), .i_mem_strobe(mstb),
        .o_rdata(rdata), .o_core_reset(core), .o_cp_bus_grant(grant),
        .o_memory_column_strobe(memory_column_strobe), .o_memory_rom_enable(mrom),
        .o_local_bus_priority(local_bus_priority), .o_master_dma_allowed(mdma), .o_pdma_active(pact),
        .o_pdma_irq(pirq), .o_hold_ack(hack), .o_system_irq_pin(irq),
        .o_parity_error(pe_o), .o_net_select_out0(ns0), .o_net_select_out1(ns1));
    // ==================================================
    // Clock and hang guard
    always #10 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // ==================================================
    // Reference model: reset defaults and host write effects
    task automatic do_reset();
        @(negedge i_clk);
        i_rst <= 1'b1;
        boot_s <= $random(seed);
        par_s <= $random(seed);
        repeat (10) @(negedge i_clk);
        i_rst <= 1'b0;
        m = 16'h0;
        m[9] = ~boot_s;
        m[10] = boot_s;
        m[12] = 1'b1;
        m[13] = par_s;
        m[15] = 1'b1;
    endtask
    task automatic w(input logic [1:0] be, input logic [15:0] d);
        logic ok;
        logic pe_old;
        ok = m[8]; // Protection looks at the bit before the write
        pe_old = m[7]; // Hold-ack clear looks at the enable before the write
        host.wr(be, d);
        if (be[0]) begin
            if (d[7]) m[7] = 1'b1;
            if (ok) m[4] = d[4];
        end
        if (!pe_old) m[4] = 1'b0;
        if (be[1]) begin
            m[8] = d[8];
            m[12:11] = d[12:11];
            if (ok) m[10:9] = d[10:9];
            if (ok) m[15:13] = d[15:13];
        end
    endtask
    // Read image plus every output against the model
    task automatic check_all();
        logic [15:0] r, e;
        logic pe, rq;
        host.rd(r);
        e = m;
        e[0] = st0;
        e[2] = st2;
        e[5] = dir;
        e[6] = intel ? breq : ~breq;
        pe = m[7];
        rq = e[6];
        chk("image", r, e);
        chk("outputs", {core, grant, local_bus_priority, mdma, pact, pirq, hack, irq, pe_o, ns1, ns0, 5'h0},
            {m[8], ~m[9] & ~m[8], m[11], ~pe, pe & rq & m[4], pe & rq & ~m[4],
             pe ? m[4] : hpin, (pe & rq & ~m[4]) | (m[12] & sirq), m[13] & perr,
             m[15:14], 5'h0});
        chk("boot_mem", {14'h0, memory_column_strobe, mrom},
            {14'h0, mstb & (m[10] | ~breg), mstb & ~m[10] & breg});
    endtask
    // ==================================================
    // Main sequence
    initial begin
        do_reset();
        check_all();
        $display("reset test done");
        w(2'h3, 16'hfa80); // Protected bits refused, enable set
        check_all();
        w(2'h2, 16'h0100); // Adapter reset on
        w(2'h3, 16'hc310); // 4M select, hold ack, halt
        check_all();
        w(2'h2, 16'h4000); // Net select {sel1,sel0} = 01, adapter reset off
        w(2'h2, 16'h8000); // Refused: adapter reset is clear
        check_all();
        $display("protected write test done");
        repeat (40) begin
            logic [15:0] d;
            @(negedge i_clk);
            {intel, st0, st2, dir, breq, hpin, sirq, perr, breg, mstb} = 10'($random(seed));
            clkmon = (($random(seed) & 7) == 0) ? 4'h1 << ($random(seed) & 3) : 4'h0;
            if (clkmon != 4'h0) m[8] = 1'b1;
            d = $random(seed);
            w(2'($random(seed)), d);
            if (clkmon != 4'h0) m[8] = 1'b1;
            check_all();
        end
        $display("random test done");
        clkmon = '0;
        do_reset();
        check_all();
        $display("second reset test done");
        hpin = 1'b1; // Pin acknowledge shows while pseudo-DMA is off
        w(2'h2, 16'h0100); // Adapter reset on, enable still clear
        w(2'h1, 16'h0010); // Hold ack refused without pseudo-DMA
        check_all();
        $display("hold ack test done");
        test_done();
    end
endmodule
